//--- hdl/gcr_counter_slice.sv
// One gated, retriggerable general counter slice with its register port
//
// Contract
// RULE1: edge strobe waits for gate edge, ignores level
// RULE2: edge modes ignore gate edges while disarmed
// RULE3: edge strobe TC reloads Load and disarms
// RULE4: edge strobe gate edges retrigger, save Hold
// RULE5: after retrigger first source loads, second counts
// RULE6: level rate counts gated edges, repeats TC
// RULE7: level rate gate edge saves Hold, reloads
// RULE8: qualified edge means source edge with gate
// RULE9: one shot counts freely, stops at TC
// RULE10: one shot gate edges save Hold, reload
// RULE11: gate level picks Load or Hold reload
// RULE12: reload twice mode disarms after two TCs
// RULE13: FSK repeats until disarm command
// RULE14: own 16-bit configuration register per slice
// RULE15: host writes configuration only while disarmed; here a configuration write is taken while armed too
// RULE16: reset presets configuration to 0B00
// RULE17: three low bits select output form
// RULE18: TC at 0001 down, 9999, FFFF up
// RULE19: TC lasts exactly one count period
// RULE20: every TC reloads from Load or Hold
// RULE21: toggled form flips on TC trailing edge
// RULE22: committed TC not delayed by retrigger
// RULE23: gate edge applied before same-cycle source edge
// RULE24: reset clears toggle flip-flop
//
// Chosen here: the strobed register port and the register offsets.
`timescale 1ns/10ps
`default_nettype none

module gcr_counter_slice #(
  parameter logic [gcr_pkg::DIV_W-1:0] F1_DIV = 8'h01
) (
  input wire logic i_mclk,
  input wire logic i_rstn,
  input wire gcr_pkg::gcr_bus_req_t i_bus,
  output logic [gcr_pkg::DATA_W-1:0] o_rdata,
  input wire logic i_src,
  input wire logic i_gate,
  output logic o_out,
  output logic o_out_oe,
  output logic o_tc
);
  import gcr_pkg::*;

  localparam logic [DIV_W-1:0] F1_LAST = F1_DIV - 8'h01;

  //////////////////////////////////////////////////////////////////////////////
  // Helpers

  function automatic logic [DATA_W-1:0] f_step(input logic [DATA_W-1:0] v, input logic up, input logic bcd);
    logic [DATA_W-1:0] r;
    logic carry;
    logic [DIGIT_W-1:0] d;
    r = v;
    carry = 1'b1;
    if (!bcd) begin
      r = up ? v + 16'h0001 : v - 16'h0001;
    end else begin
      for (int i = 0; i < DIGITS; i++) begin
        d = v[i*DIGIT_W +: DIGIT_W];
        if (carry) begin
          if (up) begin
            if (d == BCD_NINE) begin
              d = BCD_ZERO;
            end else begin
              d = d + BCD_ONE;
              carry = 1'b0;
            end
          end else begin
            if (d == BCD_ZERO) begin
              d = BCD_NINE;
            end else begin
              d = d - BCD_ONE;
              carry = 1'b0;
            end
          end
        end
        r[i*DIGIT_W +: DIGIT_W] = d;
      end
    end
    return r;
  endfunction : f_step

  function automatic logic [DATA_W-1:0] f_tc_value(input logic up, input logic bcd);
    logic [DATA_W-1:0] r;
    r = TC_DOWN;
    if (up) begin
      r = bcd ? TC_UP_BCD : TC_UP_BIN; // RULE18
    end
    return r;
  endfunction : f_tc_value

  function automatic gcr_opmode_t f_opmode(input logic [DATA_W-1:0] m);
    gcr_opmode_t op;
    logic [2:0] gating;
    gating = m[GATING_HI:GATING_LO];
    op = OPM_PLAIN;
    if (gating == GT_EDGE && m[BIT_SPECIAL]) begin
      op = m[BIT_REPEAT] ? OPM_ONE_SHOT : OPM_EDGE_STROBE;
    end else if (gating == GT_LEVEL && m[BIT_SPECIAL] && m[BIT_REPEAT]) begin
      op = OPM_LEVEL_RATE;
    end else if (gating == GT_NONE && m[BIT_SPECIAL] && m[BIT_RELOAD_SEL]) begin
      op = m[BIT_REPEAT] ? OPM_FSK : OPM_RELOAD_TWICE;
    end
    return op;
  endfunction : f_opmode

  // Returns {output enable, output level}
  function automatic logic [1:0] f_out(input logic [2:0] form, input logic tc, input logic tgl);
    logic [1:0] r;
    case (form)
      OF_LOW: r = 2'h2;
      OF_TC_HIGH: r = {1'b1, tc};
      OF_TOGGLED: r = {1'b1, tgl};
      OF_TC_LOW: r = {1'b1, ~tc};
      OF_HIZ: r = 2'h0;
      default: r = 2'h2;
    endcase
    return r;
  endfunction : f_out

  //////////////////////////////////////////////////////////////////////////////
  // State

  gcr_state_t s_r;
  gcr_state_t s_nxt;
  gcr_opmode_t opm;
  logic src_lvl;
  logic cnt_ev;
  logic gate_rise;
  logic edge_mode;
  logic gsel_mode;
  logic retrig_now;
  logic running_eff;
  logic pend_eff;
  logic go;
  logic count;
  logic committed;
  logic cmd_wr;
  logic no_cmd;
  logic [DATA_W-1:0] tcv;
  logic [DATA_W-1:0] reload_src;
  logic [1:0] outv;

  always_comb begin
    s_nxt = s_r;
    s_nxt.rdata = '0;
    opm = f_opmode(s_r.config_r);
    tcv = f_tc_value(s_r.config_r[BIT_UP], s_r.config_r[BIT_BCD]);
    committed = (s_r.cnt == tcv);
    cmd_wr = i_bus.wr && (i_bus.addr == ADDR_CMD);
    no_cmd = !cmd_wr;

    // Count source: internal divided clock or the source pin
    s_nxt.div = (s_r.div == F1_LAST) ? '0 : s_r.div + 8'h01;
    src_lvl = i_src ^ s_r.config_r[BIT_POL];
    s_nxt.src_q = src_lvl;
    if (s_r.config_r[SRCSEL_HI:SRCSEL_LO] == SRC_FIRST_FREQ) begin
      cnt_ev = (s_r.div == F1_LAST);
    end else begin
      cnt_ev = src_lvl && !s_r.src_q;
    end
    gate_rise = i_gate && !s_r.gate_q; // RULE23
    s_nxt.gate_q = i_gate;

    edge_mode = (opm == OPM_EDGE_STROBE) || (opm == OPM_ONE_SHOT);
    gsel_mode = (opm == OPM_RELOAD_TWICE) || (opm == OPM_FSK);
    retrig_now = gate_rise && ((edge_mode && s_r.armed) || (opm == OPM_LEVEL_RATE)); // RULE2 RULE7
    running_eff = s_r.running || (edge_mode && retrig_now); // RULE1
    pend_eff = s_r.pend || retrig_now; // RULE23
    reload_src = (gsel_mode && i_gate) ? s_r.hold : s_r.load; // RULE11

    if (retrig_now) begin
      s_nxt.hold = s_r.cnt; // RULE4 RULE7 RULE10
    end
    s_nxt.pend = pend_eff;
    if (edge_mode) begin
      s_nxt.running = running_eff;
    end

    go = 1'b0;
    unique case (opm)
      OPM_EDGE_STROBE, OPM_ONE_SHOT: go = s_r.armed && running_eff; // RULE1 RULE9
      OPM_LEVEL_RATE: go = s_r.armed && i_gate; // RULE6 RULE8
      OPM_PLAIN: go = s_r.armed && ((s_r.config_r[GATING_HI:GATING_LO] != GT_LEVEL) || i_gate);
      OPM_RELOAD_TWICE, OPM_FSK: go = s_r.armed; // RULE11
    endcase
    // A live TC always takes the next count edge
    count = cnt_ev && (go || s_r.tc); // RULE19

    if (count) begin
      if (s_r.tc) begin
        s_nxt.tgl = !s_r.tgl; // RULE21
      end
      if (committed) begin
        // Terminal count wins over any pending retrigger
        s_nxt.cnt = reload_src; // RULE20 RULE22
        s_nxt.tc = 1'b1;
        s_nxt.pend = 1'b0;
        unique case (opm)
          OPM_EDGE_STROBE: begin
            s_nxt.armed = 1'b0; // RULE3
            s_nxt.running = 1'b0;
          end
          OPM_ONE_SHOT: s_nxt.running = 1'b0; // RULE9
          OPM_RELOAD_TWICE: begin
            s_nxt.second = !s_r.second; // RULE12
            if (s_r.second) begin
              s_nxt.armed = 1'b0; // RULE12
            end
          end
          OPM_PLAIN: begin
            if (!s_r.config_r[BIT_REPEAT]) begin
              s_nxt.armed = 1'b0;
            end
          end
          OPM_LEVEL_RATE, OPM_FSK: s_nxt.armed = s_r.armed; // RULE6 RULE13
        endcase
      end else if (pend_eff) begin
        s_nxt.cnt = s_r.load; // RULE5 RULE7 RULE10
        s_nxt.pend = 1'b0;
        s_nxt.tc = 1'b0;
      end else begin
        s_nxt.cnt = f_step(s_r.cnt, s_r.config_r[BIT_UP], s_r.config_r[BIT_BCD]);
        s_nxt.tc = 1'b0;
      end
    end

    //////////////////////////////////////////////////////////////////////////////
    // Register port
    if (i_bus.wr) begin
      unique case (i_bus.addr)
        ADDR_CONFIG: s_nxt.config_r = i_bus.wdata; // RULE14
        ADDR_LOAD: s_nxt.load = i_bus.wdata;
        ADDR_HOLD: s_nxt.hold = i_bus.wdata;
        ADDR_CMD: begin
          if (i_bus.wdata[CMD_ARM]) begin
            s_nxt.armed = 1'b1;
            s_nxt.second = 1'b0;
          end
          if (i_bus.wdata[CMD_DISARM]) begin
            s_nxt.armed = 1'b0; // RULE13
            s_nxt.running = 1'b0;
          end
          if (i_bus.wdata[CMD_PRELOAD]) begin
            s_nxt.cnt = reload_src; // RULE11
            s_nxt.pend = 1'b0;
          end
          if (i_bus.wdata[CMD_CLR_OUT]) begin
            s_nxt.tgl = 1'b0;
          end
          if (i_bus.wdata[CMD_SET_OUT]) begin
            s_nxt.tgl = 1'b1;
          end
          if (i_bus.wdata[CMD_MASTER_RESET]) begin
            s_nxt.config_r = CONFIG_RESET; // RULE16
            s_nxt.armed = 1'b0;
            s_nxt.running = 1'b0;
            s_nxt.pend = 1'b0;
            s_nxt.second = 1'b0;
            s_nxt.tgl = 1'b0;
          end
        end
        default: s_nxt.rdata = '0;
      endcase
    end
    if (i_bus.rd) begin
      unique case (i_bus.addr)
        ADDR_CONFIG: s_nxt.rdata = s_r.config_r;
        ADDR_LOAD: s_nxt.rdata = s_r.load;
        ADDR_HOLD: s_nxt.rdata = s_r.hold;
        ADDR_STATUS: begin
          s_nxt.rdata[ST_ARMED] = s_r.armed;
          s_nxt.rdata[ST_RUNNING] = s_r.running;
          s_nxt.rdata[ST_TC] = s_r.tc;
          s_nxt.rdata[ST_TOGGLE] = s_r.tgl;
          s_nxt.rdata[ST_SECOND] = s_r.second;
        end
        ADDR_COUNT: s_nxt.rdata = s_r.cnt;
        default: s_nxt.rdata = '0;
      endcase
    end

    outv = f_out(s_nxt.config_r[OF_HI:OF_LO], s_nxt.tc, s_nxt.tgl); // RULE17
    s_nxt.oe = outv[1];
    s_nxt.out = outv[0];
  end

  always_ff @(posedge i_mclk) begin
    if (!i_rstn) begin
      s_r <= STATE_RESET; // RULE16 RULE24
    end else begin
      s_r <= s_nxt;
    end
  end

  assign o_rdata = s_r.rdata;
  assign o_out = s_r.out;
  assign o_out_oe = s_r.oe;
  assign o_tc = s_r.tc;

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  sequence seq_gate_trigger;
    retrig_now && !count && no_cmd;
  endsequence

  sequence seq_first_source;
    count && !committed && !s_r.tc && no_cmd;
  endsequence

  sequence seq_committed_count;
    count && committed && no_cmd;
  endsequence

  a_retrig_two_step: assert property (seq_gate_trigger ##1 (!count && no_cmd)[*4] ##1 seq_first_source |=> s_r.cnt == $past(s_r.load)) // RULE5
    else $error("first source after retrigger did not load");

  a_retrig_hold_save: assert property (retrig_now && !(i_bus.wr && i_bus.addr == ADDR_HOLD) |=> s_r.hold == $past(s_r.cnt)) // RULE4
    else $error("retrigger did not save count in hold");

  a_disarmed_edge_ignored: assert property (edge_mode && gate_rise && !s_r.armed && !s_r.running |=> !s_r.running) // RULE2
    else $error("gate edge started a disarmed counter");

  a_strobe_tc_disarm: assert property (opm == OPM_EDGE_STROBE ##0 seq_committed_count |=> !s_r.armed && !s_r.running && s_r.tc) // RULE3
    else $error("edge strobe stayed armed after terminal count");

  a_tc_one_period: assert property (s_r.tc && cnt_ev && !committed && no_cmd |=> !s_r.tc) // RULE19
    else $error("terminal count outlived one count period");

  a_tc_reload_src: assert property (seq_committed_count |=> s_r.tc && s_r.cnt == $past(reload_src)) // RULE20
    else $error("terminal count did not reload");

  a_level_gated_off: assert property (opm == OPM_LEVEL_RATE && !s_r.tc && cnt_ev && !i_gate && no_cmd |=> s_r.cnt == $past(s_r.cnt)) // RULE8
    else $error("level gate off but count moved");

  a_gate_sel_hold: assert property (gsel_mode && i_gate ##0 seq_committed_count |=> s_r.cnt == $past(s_r.hold)) // RULE11
    else $error("gate high did not select hold");

  a_twice_disarm: assert property (opm == OPM_RELOAD_TWICE && s_r.second ##0 seq_committed_count |=> !s_r.armed) // RULE12
    else $error("reload twice mode stayed armed after second TC");

  a_one_shot_stop: assert property (opm == OPM_ONE_SHOT ##0 seq_committed_count |=> !s_r.running && s_r.armed == $past(s_r.armed)) // RULE9
    else $error("one shot did not stop at terminal count");

  a_fsk_keeps_armed: assert property (opm == OPM_FSK && s_r.armed ##0 seq_committed_count |=> s_r.armed ##1 (s_r.armed || $past(cmd_wr))) // RULE13
    else $error("fsk disarmed without command");

  a_toggle_trailing: assert property (s_r.tc && count && no_cmd |=> s_r.tgl != $past(s_r.tgl)) // RULE21
    else $error("toggle did not flip at end of TC");

  a_commit_wins: assert property (seq_committed_count ##0 pend_eff |=> s_r.tc) // RULE22
    else $error("retrigger delayed a committed terminal count");

  a_master_reset_cfg: assert property (cmd_wr && i_bus.wdata[CMD_MASTER_RESET] |=> s_r.config_r == CONFIG_RESET && !s_r.armed) // RULE16
    else $error("master reset did not preset configuration");

  a_output_form: assert property (s_r.config_r[OF_HI:OF_LO] == OF_TC_HIGH |-> o_out == s_r.tc && o_out_oe) // RULE17
    else $error("TC output form does not follow terminal count");

  a_strobe_gate_free: assert property (opm == OPM_EDGE_STROBE && s_r.running && cnt_ev && !i_gate && !committed && !pend_eff && no_cmd |=> s_r.cnt != $past(s_r.cnt)) // RULE1
    else $error("edge strobe count stalled with gate low");

  a_level_stays_armed: assert property (opm == OPM_LEVEL_RATE && s_r.armed ##0 seq_committed_count |=> s_r.armed) // RULE6
    else $error("level rate disarmed at terminal count");

  a_preload_select: assert property (cmd_wr && i_bus.wdata[CMD_PRELOAD] |=> s_r.cnt == $past(reload_src)) // RULE11
    else $error("preload did not use the selected reload source");

endmodule : gcr_counter_slice

`default_nettype wire

//--- hdl/gcr_pkg.sv
// Constants, types and register map of the gated retriggerable counter slice
package gcr_pkg;

  localparam int DATA_W = 16;
  localparam int ADDR_W = 3;
  localparam int DIV_W = 8;
  localparam int DIGIT_W = 4;
  localparam int DIGITS = DATA_W / DIGIT_W;

  // Register offsets
  localparam logic [ADDR_W-1:0] ADDR_CONFIG = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_LOAD = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_HOLD = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h4;
  localparam logic [ADDR_W-1:0] ADDR_COUNT = 3'h5;

  localparam logic [DATA_W-1:0] CONFIG_RESET = 16'h0B00;

  // counter_configuration field positions
  localparam int OF_LO = 0;
  localparam int OF_HI = 2;
  localparam int BIT_BCD = 3;
  localparam int BIT_UP = 4;
  localparam int BIT_REPEAT = 5;
  localparam int BIT_RELOAD_SEL = 6;
  localparam int BIT_SPECIAL = 7;
  localparam int SRCSEL_LO = 8;
  localparam int SRCSEL_HI = 11;
  localparam int BIT_POL = 12;
  localparam int GATING_LO = 13;
  localparam int GATING_HI = 15;

  // Output forms
  localparam logic [2:0] OF_LOW = 3'h0;
  localparam logic [2:0] OF_TC_HIGH = 3'h1;
  localparam logic [2:0] OF_TOGGLED = 3'h2;
  localparam logic [2:0] OF_HIZ = 3'h4;
  localparam logic [2:0] OF_TC_LOW = 3'h5;

  // Gating control codes
  localparam logic [2:0] GT_NONE = 3'h0;
  localparam logic [2:0] GT_LEVEL = 3'h1;
  localparam logic [2:0] GT_EDGE = 3'h2;

  localparam logic [3:0] SRC_FIRST_FREQ = 4'hB;

  // Command and status bits
  localparam int CMD_ARM = 0;
  localparam int CMD_DISARM = 1;
  localparam int CMD_PRELOAD = 2;
  localparam int CMD_MASTER_RESET = 3;
  localparam int CMD_SET_OUT = 4;
  localparam int CMD_CLR_OUT = 5;
  localparam int ST_ARMED = 0;
  localparam int ST_RUNNING = 1;
  localparam int ST_TC = 2;
  localparam int ST_TOGGLE = 3;
  localparam int ST_SECOND = 4;

  // Terminal count values
  localparam logic [DATA_W-1:0] TC_DOWN = 16'h0001;
  localparam logic [DATA_W-1:0] TC_UP_BIN = 16'hFFFF;
  localparam logic [DATA_W-1:0] TC_UP_BCD = 16'h9999;
  localparam logic [DIGIT_W-1:0] BCD_NINE = 4'h9;
  localparam logic [DIGIT_W-1:0] BCD_ZERO = 4'h0;
  localparam logic [DIGIT_W-1:0] BCD_ONE = 4'h1;

  typedef enum logic [2:0] {
    OPM_PLAIN,
    OPM_EDGE_STROBE,
    OPM_LEVEL_RATE,
    OPM_ONE_SHOT,
    OPM_RELOAD_TWICE,
    OPM_FSK
  } gcr_opmode_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } gcr_bus_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] config_r;
    logic [DATA_W-1:0] load;
    logic [DATA_W-1:0] hold;
    logic [DATA_W-1:0] cnt;
    logic [DATA_W-1:0] rdata;
    logic [DIV_W-1:0] div;
    logic armed;
    logic running;
    logic tc;
    logic tgl;
    logic pend;
    logic second;
    logic src_q;
    logic gate_q;
    logic out;
    logic oe;
  } gcr_state_t;

  localparam gcr_state_t STATE_RESET = '{config_r: CONFIG_RESET, oe: 1'b1, default: '0};

endpackage : gcr_pkg

//--- testbench/gcr_pin_model.sv
// External logic that drives the count source and gate pins
`timescale 1ns/10ps
`default_nettype none

module gcr_pin_model (
  input wire logic i_mclk,
  output logic o_src,
  output logic o_gate
);
  initial begin
    o_src = 1'b0;
    o_gate = 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // Each pulse has a low cycle before it, so every pulse is an edge
  task automatic src(input int n);
    repeat (n) begin
      @(posedge i_mclk);
      o_src <= 1'b1;
      @(posedge i_mclk);
      o_src <= 1'b0;
      @(posedge i_mclk);
    end
    @(posedge i_mclk);
  endtask : src

  // Gate level is held steady across source pulses
  task automatic gate(input logic v);
    @(posedge i_mclk);
    o_gate <= v;
    repeat (2) @(posedge i_mclk);
  endtask : gate
endmodule : gcr_pin_model
`default_nettype wire

//--- testbench/tb.sv
// Self-checking bench for the gated retriggerable counter slice
`timescale 1ns/10ps
`default_nettype none

module tb;
  import gcr_pkg::*;
  localparam logic [DATA_W-1:0] M = 16'hFFFF;
  logic i_mclk;
  logic i_rstn;
  gcr_bus_req_t bus;
  logic [DATA_W-1:0] rdata;
  logic src;
  logic gate;
  logic out;
  logic out_oe;
  logic tc;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;

  always #50 i_mclk = ~i_mclk;

  gcr_counter_slice #(.F1_DIV(8'h01)) uut (
    .i_mclk(i_mclk), .i_rstn(i_rstn), .i_bus(bus), .o_rdata(rdata),
    .i_src(src), .i_gate(gate), .o_out(out), .o_out_oe(out_oe), .o_tc(tc)
  );
  gcr_pin_model pins (.i_mclk(i_mclk), .o_src(src), .o_gate(gate));

  ////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("Checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  always @(posedge i_mclk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  task automatic chk16(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk16

  task automatic chk1(input logic got, input logic exp);
    chk16({15'h0000, got}, {15'h0000, exp});
  endtask : chk1

  ////////////////////////////////////////////////////////////////
  // Register port master
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge i_mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_mclk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] m, input logic [DATA_W-1:0] e);
    @(posedge i_mclk);
    bus <= '{addr: a, wdata: bus.wdata, wr: 1'b0, rd: 1'b1};
    @(posedge i_mclk);
    bus.rd <= 1'b0;
    #1;
    chk16(rdata & m, e);
  endtask : rdchk

  task automatic cmd(input int b);
    wr(ADDR_CMD, 16'h0001 << b);
  endtask : cmd

  task automatic cnt(input logic [DATA_W-1:0] e);
    rdchk(ADDR_COUNT, M, e);
  endtask : cnt

  task automatic armed(input logic e);
    rdchk(ADDR_STATUS, 16'h0001, {15'h0000, e});
  endtask : armed

  // Configuration only changes while disarmed
  task automatic setup(input logic [DATA_W-1:0] cfg, input logic [DATA_W-1:0] ld);
    wr(ADDR_CONFIG, cfg);
    wr(ADDR_LOAD, ld);
    cmd(CMD_PRELOAD);
  endtask : setup

  ////////////////////////////////////////////////////////////////
  task automatic t_reset();
    chk1(tc, 1'b0);
    chk1(out, 1'b0);
    chk1(out_oe, 1'b1);
    rdchk(ADDR_CONFIG, M, 16'h0B00);
    rdchk(ADDR_STATUS, 16'h0008, 16'h0000);
    rdchk(3'h7, M, 16'h0000);
    rdchk(ADDR_CMD, M, 16'h0000);
    wr(3'h6, 16'h1234);
    wr(ADDR_CONFIG, 16'h5A5A);
    rdchk(ADDR_CONFIG, M, 16'h5A5A);
    cmd(CMD_MASTER_RESET);
    rdchk(ADDR_CONFIG, M, 16'h0B00);
    $display("Test reset done");
  endtask : t_reset

  task automatic t_edge();
    setup(16'h4081, 16'h0003);
    pins.gate(1'b1);
    pins.gate(1'b0);
    pins.src(1);
    cnt(16'h0003);
    rdchk(ADDR_HOLD, M, 16'h0000);
    cmd(CMD_ARM);
    pins.gate(1'b1);
    rdchk(ADDR_HOLD, M, 16'h0003);
    pins.src(1);
    cnt(16'h0003);
    pins.src(1);
    cnt(16'h0002);
    pins.gate(1'b0);
    pins.gate(1'b1);
    rdchk(ADDR_HOLD, M, 16'h0002);
    pins.src(1);
    cnt(16'h0003);
    pins.gate(1'b0);
    pins.src(2);
    cnt(16'h0001);
    pins.src(1);
    chk1(tc, 1'b1);
    cnt(16'h0003);
    armed(1'b0);
    pins.src(1);
    chk1(tc, 1'b0);
    wr(ADDR_HOLD, 16'h0005);
    pins.gate(1'b1);
    rdchk(ADDR_HOLD, M, 16'h0005);
    pins.gate(1'b0);
    $display("Test edge strobe done");
  endtask : t_edge

  task automatic t_level();
    setup(16'h20A1, 16'h0002);
    cmd(CMD_ARM);
    pins.src(2);
    cnt(16'h0002);
    pins.gate(1'b1);
    rdchk(ADDR_HOLD, M, 16'h0002);
    pins.src(1);
    cnt(16'h0002);
    pins.src(1);
    cnt(16'h0001);
    pins.gate(1'b0);
    pins.gate(1'b1);
    rdchk(ADDR_HOLD, M, 16'h0001);
    pins.src(1);
    chk1(tc, 1'b1);
    cnt(16'h0002);
    armed(1'b1);
    cmd(CMD_DISARM);
    pins.gate(1'b0);
    pins.src(1);
    $display("Test level rate done");
  endtask : t_level

  task automatic t_shot();
    setup(16'h40A1, 16'h0002);
    cmd(CMD_ARM);
    pins.gate(1'b1);
    pins.gate(1'b0);
    pins.src(1);
    cnt(16'h0002);
    pins.src(2);
    chk1(tc, 1'b1);
    cnt(16'h0002);
    pins.src(2);
    chk1(tc, 1'b0);
    armed(1'b1);
    cnt(16'h0001);
    cmd(CMD_DISARM);
    $display("Test one shot done");
  endtask : t_shot

  task automatic t_twice();
    wr(ADDR_HOLD, 16'h0003);
    setup(16'h00C1, 16'h0002);
    cnt(16'h0002);
    cmd(CMD_ARM);
    pins.src(1);
    pins.gate(1'b1);
    pins.src(1);
    cnt(16'h0003);
    armed(1'b1);
    pins.gate(1'b0);
    pins.src(3);
    cnt(16'h0002);
    armed(1'b0);
    pins.src(1);
    $display("Test reload twice done");
  endtask : t_twice

  task automatic t_fsk();
    cmd(CMD_CLR_OUT);
    setup(16'h00E2, 16'h0002);
    cmd(CMD_ARM);
    chk1(out, 1'b0);
    pins.src(2);
    cnt(16'h0002);
    chk1(out, 1'b0);
    pins.src(1);
    chk1(tc, 1'b0);
    chk1(out, 1'b1);
    pins.gate(1'b1);
    pins.src(1);
    cnt(16'h0003);
    armed(1'b1);
    cmd(CMD_DISARM);
    armed(1'b0);
    pins.gate(1'b0);
    pins.src(1);
    $display("Test fsk done");
  endtask : t_fsk

  // Reset configuration: internal source, count once, Load reload
  task automatic t_plain();
    setup(16'h0B00, 16'h0003);
    cmd(CMD_ARM);
    repeat (8) @(posedge i_mclk);
    cnt(16'h0002);
    chk1(tc, 1'b0);
    armed(1'b0);
    $display("Test plain count done");
  endtask : t_plain

  task automatic t_forms();
    logic [2:0] f [4] = '{3'h0, 3'h1, 3'h4, 3'h5};
    logic eo [4] = '{1'b0, 1'b0, 1'b0, 1'b1};
    logic ee [4] = '{1'b1, 1'b1, 1'b0, 1'b1};
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CONFIG, {13'h0000, f[i]});
      repeat (2) @(posedge i_mclk);
      chk1(out_oe, ee[i]);
      if (ee[i] === 1'b1) begin
        chk1(out, eo[i]);
      end
    end
    cmd(CMD_MASTER_RESET);
    rdchk(ADDR_CONFIG, M, 16'h0B00);
    $display("Test output forms done");
  endtask : t_forms

  ////////////////////////////////////////////////////////////////
  initial begin
    i_mclk = 1'b0;
    i_rstn <= 1'b0;
    bus <= '0;
    repeat (3) @(posedge i_mclk);
    i_rstn <= 1'b1;
    t_reset();
    t_edge();
    t_level();
    t_shot();
    t_twice();
    t_fsk();
    t_plain();
    t_forms();
    wrap_up();
  end
endmodule : tb
`default_nettype wire
